/* ahc_dev.sv */
// front-end device end: serial slave with trigger, lock and enable words
`timescale 1ns/1ps
module ahc_dev
   import ahc_pkg::*;
#(
   parameter int unsigned CLK_HZ      = AHC_CLK_HZ,
   parameter int unsigned FS_NUM      = AHC_FS_NUM,
   parameter int unsigned FS_DEN      = AHC_FS_DEN,
   parameter int unsigned SAMPLES     = AHC_SAMPLES_PER_INTERVAL,
   parameter int unsigned CONV_CYCLES = AHC_TEMP_CONV_CYCLES
) (
   input  wire logic ref_clk,
   input  wire logic arst_n,
   ahc_link_if.dev   link,
   output logic      adc_en,
   output logic      ce_en,
   output logic      port_locked,
   output logic      sample_strobe,
   output logic      interval_done,
   output logic      temp_busy,
   output logic      temp_done
);
   localparam logic [29:0] PH_STEP = 30'(FS_NUM);
   localparam logic [29:0] PH_WRAP = 30'(CLK_HZ * FS_DEN);
   localparam logic [11:0] SAMP_LAST = 12'(SAMPLES - 1);
   localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);

   // link state
   logic        sck_q;
   logic [5:0]  bit_cnt;
   logic [31:0] rx_shift;
   logic [31:0] tx_shift;
   logic [15:0] hdr;
   logic        miso_q;

   // registers
   logic        trig_bit;
   logic        lock_bit;
   logic [1:0]  temp_per;
   logic [1:0]  meter_en;

   // measurement cadence
   logic [29:0] ph_acc;
   logic [11:0] samp_cnt;
   ahc_conv_state_t conv_state;
   logic [15:0] conv_cnt;

   // link decode
   wire         sck_rise = link.sck & ~sck_q & ~link.cs_n;
   wire         sck_fall = ~link.sck & sck_q & ~link.cs_n;
   wire [15:0]  next_hdr = {rx_shift[14:0], link.mosi};
   wire [31:0]  next_word = {rx_shift[30:0], link.mosi};
   wire [14:0]  rd_addr = next_hdr[14:0];
   wire         hdr_done = sck_rise & (bit_cnt == AHC_HDR_LAST);
   wire         frame_done = sck_rise & (bit_cnt == AHC_FRAME_LAST);
   wire         wr_addr_lock = hdr[14:0] == AHC_IDX_LOCK;
   wire         rd_allowed = ~lock_bit | (rd_addr == AHC_IDX_LOCK);
   wire         wr_allowed = ~lock_bit | wr_addr_lock;
   wire         wr_ok = frame_done & hdr[15] & wr_allowed;
   wire         wr_set = next_word == AHC_CMD_SET;
   wire         wr_clr = next_word == AHC_CMD_CLEAR;

   // register read selection
   wire [31:0]  rd_raw =
      (rd_addr == AHC_IDX_TEMP_CNF)  ? {28'h0, temp_per, 2'h0} :
      (rd_addr == AHC_IDX_TEMP_TRIG) ? {trig_bit, 31'h0} :
      (rd_addr == AHC_IDX_LOCK)      ? {lock_bit, 31'h0} :
      (rd_addr == AHC_IDX_METER_EN)  ? {30'h0, meter_en} :
                                       AHC_RESET_WORD;
   wire [31:0]  rd_word = rd_allowed ? rd_raw : AHC_RESET_WORD;

   // register write decode
   wire wr_cnf  = wr_ok & (hdr[14:0] == AHC_IDX_TEMP_CNF);
   wire wr_trig = wr_ok & (hdr[14:0] == AHC_IDX_TEMP_TRIG) & wr_set;
   wire wr_lock = wr_ok & wr_addr_lock;
   wire wr_men  = wr_ok & (hdr[14:0] == AHC_IDX_METER_EN);

   // enables follow the written word in the same cycle it lands
   wire next_men_adc = wr_men ? next_word[AHC_ADC_EN_BIT] : meter_en[0];
   wire next_men_ce  = wr_men ? next_word[AHC_CE_EN_BIT] : meter_en[1];

   // sampling phase accumulator, exact fs = FS_NUM / FS_DEN on average
   // no strobe in the cycle that turns the converters off
   wire [29:0]  ph_sum = ph_acc + PH_STEP;
   wire         ph_hit = adc_en & next_men_adc &
                         (ph_sum >= PH_WRAP);
   wire [29:0]  next_ph = ~adc_en ? 30'h0 :
                          ph_hit ? ph_sum - PH_WRAP : ph_sum;
   wire         samp_tick = ph_hit & ce_en & next_men_ce;
   wire         samp_wrap = samp_tick & (samp_cnt == SAMP_LAST);
   wire [11:0]  next_samp = ~ce_en ? 12'h0 :
                            samp_wrap ? 12'h0 :
                            samp_tick ? samp_cnt + 12'h1 : samp_cnt;

   // temperature conversion start and end
   wire auto_start =
      ((temp_per == AHC_PER_ACCUM) & samp_wrap) |
      (temp_per == AHC_PER_CONT);
   wire conv_idle = conv_state == AHC_CONV_IDLE;
   wire conv_start = conv_idle & (trig_bit | auto_start);
   wire conv_end = (conv_state == AHC_CONV_BUSY) & (conv_cnt == CONV_LAST);
   wire next_trig = wr_trig | (trig_bit & ~conv_end);
   wire next_lock = wr_lock ? (wr_set ? 1'b1 :
                               wr_clr ? 1'b0 : lock_bit) : lock_bit;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sck_q    <= 1'b0;
         bit_cnt  <= 6'h0;
         rx_shift <= AHC_RESET_WORD;
         hdr      <= 16'h0;
      end else begin
         sck_q <= link.sck;
         if (link.cs_n) begin
            bit_cnt <= 6'h0;
         end else if (sck_rise) begin
            bit_cnt  <= bit_cnt + 6'h1;
            rx_shift <= next_word;
            if (hdr_done) begin
               hdr <= next_hdr;
            end
         end
      end
   end

   // read data leaves on falling edges after the header
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         tx_shift <= AHC_RESET_WORD;
         miso_q   <= 1'b0;
      end else if (link.cs_n) begin
         miso_q <= 1'b0;
      end else if (hdr_done) begin
         tx_shift <= next_hdr[15] ? AHC_RESET_WORD : rd_word;
      end else if (sck_fall && bit_cnt >= AHC_DATA_FIRST) begin
         miso_q   <= tx_shift[AHC_TOP_BIT];
         tx_shift <= {tx_shift[30:0], 1'b0};
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         trig_bit <= 1'b0;
         lock_bit <= 1'b0;
         temp_per <= 2'h0;
         meter_en <= 2'h0;
      end else begin
         trig_bit <= next_trig;
         lock_bit <= next_lock;
         if (wr_cnf) begin
            temp_per <= next_word[AHC_TEMP_PER_HI:AHC_TEMP_PER_LO];
         end
         if (wr_men) begin
            meter_en <= {next_word[AHC_CE_EN_BIT],
                         next_word[AHC_ADC_EN_BIT]};
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ph_acc   <= 30'h0;
         samp_cnt <= 12'h0;
      end else begin
         ph_acc   <= next_ph;
         samp_cnt <= next_samp;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         conv_state <= AHC_CONV_IDLE;
         conv_cnt   <= 16'h0;
      end else begin
         case (conv_state)
            AHC_CONV_IDLE: begin
               conv_cnt <= 16'h0;
               if (conv_start) begin
                  conv_state <= AHC_CONV_BUSY;
               end
            end
            AHC_CONV_BUSY: begin
               conv_cnt <= conv_cnt + 16'h1;
               if (conv_end) begin
                  conv_state <= AHC_CONV_IDLE;
               end
            end
            default: begin
               conv_state <= AHC_CONV_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         adc_en        <= 1'b0;
         ce_en         <= 1'b0;
         port_locked   <= 1'b0;
         sample_strobe <= 1'b0;
         interval_done <= 1'b0;
         temp_busy     <= 1'b0;
         temp_done     <= 1'b0;
      end else begin
         adc_en        <= next_men_adc;
         ce_en         <= next_men_ce;
         port_locked   <= next_lock;
         sample_strobe <= ph_hit;
         interval_done <= samp_wrap;
         temp_busy     <= ~conv_end & (conv_start | ~conv_idle);
         temp_done     <= conv_end;
      end
   end

   assign link.miso = miso_q;
endmodule

/* ahc_host.sv */
// host controller end: serial master issuing single register frames
`timescale 1ns/1ps
module ahc_host
   import ahc_pkg::*;
#(
   parameter int unsigned SCK_HALF = AHC_SCK_HALF
) (
   input  wire logic        ref_clk,
   input  wire logic        arst_n,
   ahc_link_if.host         link,
   input  wire logic        req,
   input  wire logic        req_write,
   input  wire logic [14:0] req_addr,
   input  wire logic [31:0] req_wdata,
   output logic             busy,
   output logic             done,
   output logic [31:0]      rdata
);
   localparam logic [7:0] HALF_LAST = 8'(SCK_HALF - 1);

   ahc_host_state_t state;
   logic [7:0]  div_cnt;
   logic [5:0]  edge_cnt;
   logic [47:0] tx_shift;
   logic [31:0] rx_shift;
   logic        sck_q;
   logic        cs_n_q;
   logic        mosi_q;

   wire half_tick = div_cnt == HALF_LAST;
   wire do_rise = (state == AHC_HOST_SHIFT) & half_tick & ~sck_q;
   wire do_fall = (state == AHC_HOST_SHIFT) & half_tick & sck_q;
   wire last_fall = do_fall & (edge_cnt == 6'(AHC_FRAME_BITS));
   // a zero write to the lock word is an ordinary frame
   wire [47:0] frame = {req_write, req_addr,
                        req_write ? req_wdata : AHC_RESET_WORD};
   wire [7:0] next_div = (state == AHC_HOST_IDLE) ? 8'h0 :
                         half_tick ? 8'h0 : div_cnt + 8'h1;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state    <= AHC_HOST_IDLE;
         div_cnt  <= 8'h0;
         edge_cnt <= 6'h0;
         tx_shift <= 48'h0;
         rx_shift <= AHC_RESET_WORD;
         sck_q    <= 1'b0;
         cs_n_q   <= 1'b1;
         mosi_q   <= 1'b0;
         busy     <= 1'b0;
         done     <= 1'b0;
         rdata    <= AHC_RESET_WORD;
      end else begin
         div_cnt <= next_div;
         done    <= 1'b0;
         case (state)
            AHC_HOST_IDLE: begin
               busy <= 1'b0;
               if (req) begin
                  state    <= AHC_HOST_SHIFT;
                  busy     <= 1'b1;
                  edge_cnt <= 6'h0;
                  tx_shift <= frame;
                  mosi_q   <= frame[47];
                  cs_n_q   <= 1'b0;
               end
            end
            AHC_HOST_SHIFT: begin
               if (do_rise) begin
                  sck_q    <= 1'b1;
                  edge_cnt <= edge_cnt + 6'h1;
                  rx_shift <= {rx_shift[30:0], link.miso};
               end
               if (do_fall) begin
                  sck_q    <= 1'b0;
                  tx_shift <= {tx_shift[46:0], 1'b0};
                  mosi_q   <= tx_shift[46];
               end
               if (last_fall) begin
                  state  <= AHC_HOST_GAP;
                  cs_n_q <= 1'b1;
                  mosi_q <= 1'b0;
                  rdata  <= rx_shift;
                  done   <= 1'b1;
               end
            end
            AHC_HOST_GAP: begin
               // lets the device see the deselect before the next frame
               if (half_tick) begin
                  state <= AHC_HOST_IDLE;
                  busy  <= 1'b0;
               end
            end
            default: begin
               state <= AHC_HOST_IDLE;
            end
         endcase
      end
   end

   assign link.sck  = sck_q;
   assign link.cs_n = cs_n_q;
   assign link.mosi = mosi_q;
endmodule

/* ahc_link_asserts.sv */
// checker on the serial link and the device outputs
`timescale 1ns/1ps
module ahc_link_asserts #(
   parameter int unsigned SAMPLES     = 4,
   parameter int unsigned CONV_CYCLES = 64,
   parameter int unsigned GAP         = 26
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic adc_en,
   input wire logic ce_en,
   input wire logic port_locked,
   input wire logic sample_strobe,
   input wire logic interval_done,
   input wire logic temp_busy,
   input wire logic temp_done
);
   logic [15:0] gcnt;
   logic [15:0] scnt;
   logic [15:0] bcnt;
   logic        seen;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // strobe spacing, strobes per interval, busy length
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         gcnt <= '0;
         scnt <= '0;
         bcnt <= '0;
         seen <= 1'b0;
      end else begin
         gcnt <= sample_strobe ? 16'h0 : gcnt + 16'h1;
         seen <= adc_en && (seen || sample_strobe);
         scnt <= (!ce_en || interval_done) ? 16'h0 :
                 scnt + 16'(sample_strobe);
         bcnt <= (temp_busy && !temp_done) ? bcnt + 16'h1 : 16'h0;
      end
   end
   AST_LOCK_SET: assert property ($rose(port_locked) |-> !cs_n)
      else $error("lock set outside a frame");
   AST_LOCK_CLR: assert property ($fell(port_locked) |-> !cs_n)
      else $error("lock cleared outside a frame");
   AST_ADC_CHG: assert property ($changed(adc_en) |-> !cs_n)
      else $error("converter enable moved outside a frame");
   AST_CE_CHG: assert property ($changed(ce_en) |-> !cs_n)
      else $error("engine enable moved outside a frame");
   AST_STB_EN: assert property (sample_strobe |-> adc_en)
      else $error("sample strobe while converters off");
   AST_STB_GAP: assert property (sample_strobe && seen |->
      gcnt == GAP - 1) else $error("sample strobe spacing wrong");
   AST_IVL_EN: assert property (interval_done |-> ce_en && adc_en)
      else $error("interval end while engine off");
   AST_IVL_CNT: assert property (interval_done |->
      scnt >= SAMPLES - 1) else $error("interval ended early");
   AST_IVL_MAX: assert property (scnt <= SAMPLES)
      else $error("interval overran its sample count");
   AST_BUSY_LEN: assert property (bcnt <= CONV_CYCLES)
      else $error("conversion ran too long");
   AST_DONE_END: assert property (temp_done |-> $past(temp_busy))
      else $error("conversion end without a conversion");
   AST_LINK_IDLE: assert property (cs_n |-> !sck && !mosi)
      else $error("link clock or data active outside a frame");
   AST_MISO_IDLE: assert property ($past(cs_n) |-> !miso)
      else $error("device drives data outside a frame");
   cover property (port_locked && $fell(cs_n));
   cover property (interval_done);
   cover property (temp_done);
endmodule

/* ahc_link_if.sv */
// serial link between the host controller and the front-end device
`timescale 1ns/1ps
interface ahc_link_if;
   logic sck;
   logic cs_n;
   logic mosi;
   logic miso;

   modport host (
      output sck,
      output cs_n,
      output mosi,
      input  miso
   );

   modport dev (
      input  sck,
      input  cs_n,
      input  mosi,
      output miso
   );
endinterface

/* ahc_pkg.sv */
// shared constants for the host control register bank and its serial link
package ahc_pkg;
   // link frame: write flag, word index, 32-bit data, msb first
   localparam int unsigned       AHC_ADDR_W      = 15;
   localparam int unsigned       AHC_DATA_W      = 32;
   localparam int unsigned       AHC_HDR_BITS    = 16;
   localparam int unsigned       AHC_FRAME_BITS  = 48;
   localparam logic [5:0]        AHC_HDR_LAST    = 6'h0f;
   localparam logic [5:0]        AHC_FRAME_LAST  = 6'h2f;
   localparam logic [5:0]        AHC_DATA_FIRST  = 6'h10;

   // word indices of the registers
   localparam logic [14:0]       AHC_IDX_TEMP_CNF  = 15'h323;
   localparam logic [14:0]       AHC_IDX_TEMP_TRIG = 15'h324;
   localparam logic [14:0]       AHC_IDX_LOCK      = 15'h325;
   localparam logic [14:0]       AHC_IDX_METER_EN  = 15'h326;

   // command values and reset values
   localparam logic [31:0]       AHC_CMD_SET       = 32'h8000_0000;
   localparam logic [31:0]       AHC_CMD_CLEAR     = 32'h0000_0000;
   localparam logic [31:0]       AHC_RESET_WORD    = 32'h0000_0000;
   localparam int unsigned       AHC_TOP_BIT       = 31;

   // field positions
   localparam int unsigned       AHC_TEMP_PER_LO   = 2;
   localparam int unsigned       AHC_TEMP_PER_HI   = 3;
   localparam int unsigned       AHC_ADC_EN_BIT    = 0;
   localparam int unsigned       AHC_CE_EN_BIT     = 1;
   localparam logic [1:0]        AHC_PER_ACCUM     = 2'h1;
   localparam logic [1:0]        AHC_PER_CONT      = 2'h2;

   // timing
   localparam int unsigned       AHC_CLK_HZ        = 20_000_000;
   localparam int unsigned       AHC_CLK_PERIOD_NS = 50;
   localparam int unsigned       AHC_FS_NUM        = 32768;
   localparam int unsigned       AHC_FS_DEN        = 13;
   localparam int unsigned       AHC_SAMPLES_PER_INTERVAL = 2520;
   localparam int unsigned       AHC_TEMP_CONV_CYCLES     = 64;
   localparam int unsigned       AHC_SCK_HALF      = 4;

   typedef enum logic [0:0] {
      AHC_CONV_IDLE,
      AHC_CONV_BUSY
   } ahc_conv_state_t;

   typedef enum logic [1:0] {
      AHC_HOST_IDLE,
      AHC_HOST_SHIFT,
      AHC_HOST_GAP
   } ahc_host_state_t;
endpackage

/* test_afe_host_control_regs.sv */
// self-checking bench joining the host end and the device end
`timescale 1ns/1ps
module test_afe_host_control_regs
   import ahc_pkg::*;
;
   localparam int unsigned CLK_HZ  = 65536;
   localparam int unsigned SAMPLES = 4;
   localparam int unsigned GAP     = CLK_HZ * AHC_FS_DEN / AHC_FS_NUM;
   logic        ref_clk   = 1'b0;
   logic        arst_n    = 1'b0;
   logic        req       = 1'b0;
   logic        req_write = 1'b0;
   logic [14:0] req_addr  = '0;
   logic [31:0] req_wdata = '0;
   logic        busy, done, adc_en, ce_en, port_locked;
   logic        sample_strobe, interval_done, temp_busy, temp_done;
   logic [31:0] rdata, rd, d;
   logic [14:0] regs [4];
   int          failures  = 0;
   int          cmp_count = 0;
   int          seed      = 32'h47f483e4;
   int          n;
   ahc_link_if link ();
   ahc_host ahc_host_i (.ref_clk(ref_clk), .arst_n(arst_n), .link(link),
      .req(req), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .busy(busy), .done(done), .rdata(rdata));
   ahc_dev #(.CLK_HZ(CLK_HZ), .SAMPLES(SAMPLES)) ahc_dev_i (
      .ref_clk(ref_clk), .arst_n(arst_n), .link(link), .adc_en(adc_en),
      .ce_en(ce_en), .port_locked(port_locked),
      .sample_strobe(sample_strobe), .interval_done(interval_done),
      .temp_busy(temp_busy), .temp_done(temp_done));
   ahc_link_asserts #(.SAMPLES(SAMPLES),
      .CONV_CYCLES(AHC_TEMP_CONV_CYCLES), .GAP(GAP)) ahc_link_asserts_i (
      .ref_clk(ref_clk), .arst_n(arst_n), .sck(link.sck),
      .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso),
      .adc_en(adc_en), .ce_en(ce_en), .port_locked(port_locked),
      .sample_strobe(sample_strobe), .interval_done(interval_done),
      .temp_busy(temp_busy), .temp_done(temp_done));
   always #(AHC_CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
   function automatic logic [31:0] meter_exp(input logic [31:0] v);
      return v & 32'h3;
   endfunction
   function automatic int ivl_cycles();
      return SAMPLES * GAP;
   endfunction
   function automatic logic auto_run(input logic [1:0] c);
      return c == AHC_PER_ACCUM || c == AHC_PER_CONT;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t saw %h wanted %h", $time, got, exp);
      end
   endtask
   // one frame; read data lands in rd
   task automatic xfer(input logic w, input logic [14:0] a,
                       input logic [31:0] v);
      int k;
      k = 0;
      @(posedge ref_clk);
      req       <= 1'b1;
      req_write <= w;
      req_addr  <= a;
      req_wdata <= v;
      do @(negedge ref_clk); while (busy !== 1'b1 && ++k < 20);
      @(posedge ref_clk);
      req <= 1'b0;
      do @(negedge ref_clk); while (done !== 1'b1 && ++k < 2000);
      rd = rdata;
      do @(negedge ref_clk); while (busy !== 1'b0 && ++k < 2000);
      if (k >= 2000) begin
         failures++;
         $display("[FAIL] %0t frame never finished", $time);
      end
   endtask
   task automatic close_out();
      $display("compares %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #(AHC_CLK_PERIOD_NS * 60000);
      failures++;
      close_out();
   end
   initial begin
      regs = '{AHC_IDX_TEMP_TRIG, AHC_IDX_LOCK, AHC_IDX_METER_EN, 15'h100};
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      chk(32'({adc_en, ce_en, port_locked, temp_busy}), 32'h0);
      foreach (regs[i]) begin
         xfer(1'b0, regs[i], 32'h0);
         chk(rd, AHC_RESET_WORD);
      end
      for (int i = 0; i < 4; i++) begin
         d = (i == 3) ? 32'h3 : $random(seed);
         xfer(1'b1, AHC_IDX_METER_EN, d);
         chk(32'({ce_en, adc_en}), meter_exp(d));
         xfer(1'b0, AHC_IDX_METER_EN, 32'h0);
         chk(rd & 32'h3, meter_exp(d));
      end
      n = 0;
      do @(negedge ref_clk); while (interval_done !== 1'b1 && ++n < 1000);
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (interval_done !== 1'b1 && n < 1000);
      chk(32'(n), 32'(ivl_cycles()));
      xfer(1'b1, AHC_IDX_LOCK, AHC_CMD_SET);
      chk(32'(port_locked), 32'h1);
      xfer(1'b0, AHC_IDX_LOCK, 32'h0);
      chk(rd, AHC_CMD_SET);
      xfer(1'b1, AHC_IDX_METER_EN, 32'h0);
      xfer(1'b1, AHC_IDX_TEMP_TRIG, AHC_CMD_SET);
      chk(32'({temp_busy, ce_en, adc_en}), 32'h3);
      xfer(1'b0, AHC_IDX_METER_EN, 32'h0);
      chk(rd, 32'h0);
      xfer(1'b1, AHC_IDX_LOCK, $random(seed) | 32'h1);
      chk(32'(port_locked), 32'h1);
      xfer(1'b1, AHC_IDX_LOCK, AHC_CMD_CLEAR);
      chk(32'(port_locked), 32'h0);
      xfer(1'b0, AHC_IDX_METER_EN, 32'h0);
      chk(rd & 32'h3, 32'h3);
      xfer(1'b1, AHC_IDX_TEMP_TRIG, AHC_CMD_SET);
      chk(32'(temp_busy), 32'h1);
      n = 0;
      do @(negedge ref_clk); while (temp_done !== 1'b1 && ++n < 200);
      chk(32'(n < 200), 32'h1);
      xfer(1'b0, AHC_IDX_TEMP_TRIG, 32'h0);
      chk(rd, AHC_CMD_CLEAR);
      for (int c = 0; c < 4; c++) begin
         xfer(1'b1, AHC_IDX_TEMP_CNF, 32'(c) << AHC_TEMP_PER_LO);
         repeat (AHC_TEMP_CONV_CYCLES + 8) @(negedge ref_clk);
         n = 0;
         repeat (3 * ivl_cycles()) @(negedge ref_clk) n += int'(temp_done);
         chk(32'(n > 0), 32'(auto_run(2'(c))));
      end
      xfer(1'b1, AHC_IDX_TEMP_CNF, 32'h0);
      close_out();
   end
endmodule
